/* File: verilog/occ_top.sv */
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ps
module occ_top
   import occ_pkg::*;
(
   // clock and reset
   input  wire logic              i_clock,
   input  wire logic              i_reset,
   // register port
   input  wire occ_pkg::occ_bus_t i_bus,
   output logic [15:0]            o_rdata,
   // oscillator status and events
   input  wire logic              i_fail_detect,
   input  wire logic              i_new_src_ready,
   input  wire logic              i_new_src_tick,
   input  wire logic              i_pll_lock,
   input  wire logic              i_unlocked,
   input  wire logic              i_lock_one_shot,
   input  wire logic [2:0]        i_initial_osc_config,
   input  wire logic              i_irq,
   input  wire logic              i_sleep,
   input  wire logic              i_idle,
   // self-tune measurement
   input  wire logic              i_tune_in_tol,
   input  wire logic              i_tune_out_range,
   input  wire logic              i_tune_up,
   input  wire logic              i_tune_down,
   // control outputs
   output occ_pkg::occ_ctl_t      o_ctl
);
   import occ_pkg::*;

   // ****************************************************
   // state
   // ****************************************************
   typedef struct packed {
      occ_sw_t     sw;
      logic [3:0]  cnt;
      logic        started;
      logic        switch_req;
      logic        sosc_en;
      logic        posc_keep;
      logic        clk_fail;
      logic        pll_settled;
      logic        pin_lock;
      logic [2:0]  next_osc;
      logic [2:0]  cur_osc;
      logic        recover;
      logic [2:0]  ratio_sel;
      logic        ratio_en;
      logic [2:0]  div_src;
      logic [1:0]  postscale;
      logic        pll_force;
      logic        tune_en;
      logic        idle_stop;
      logic        ref_sel;
      logic        in_tol;
      logic        tol_pol;
      logic        out_range;
      logic        range_pol;
      logic [5:0]  frc_trim;
      logic [5:0]  dco_trim;
      logic        dco_keep;
      logic [3:0]  dco_fsel;
      logic [14:0] divisor;
      logic [15:0] rdata;
      occ_ctl_t    ctl;
   } occ_state_t;

   occ_state_t st;
   occ_state_t next_st;

   logic       wr_osc;
   logic       tune_active;
   logic [5:0] trim_step;

   assign wr_osc = i_bus.wr && (i_bus.addr == ADDR_OSC_CONTROL);
   // tuner freezes in idle when asked, and never steps out of range
   assign tune_active = st.tune_en && !(st.idle_stop && i_idle)
                        && !st.out_range;
   assign trim_step = i_tune_up ? 6'h01 : 6'h3f;

   // ****************************************************
   // next state
   // ****************************************************
   always_comb begin
      next_st = st;
      // first cycle after reset latches the configured start oscillator
      if (!st.started) begin
         next_st.started = 1'b1;
         next_st.cur_osc = i_initial_osc_config;
         next_st.next_osc = i_initial_osc_config;
      end

      // register writes
      if (i_bus.wr) begin
         case (i_bus.addr)
            ADDR_OSC_CONTROL: begin
               next_st.next_osc = i_bus.wdata[POS_NEXT_OSC +: 3];
               next_st.posc_keep = i_bus.wdata[POS_POSC_KEEP];
               next_st.sosc_en = i_bus.wdata[POS_SOSC_EN];
               if (i_bus.wdata[POS_SWITCH_REQ]) begin
                  next_st.switch_req = 1'b1;
               end
               if (i_unlocked && !(i_lock_one_shot && st.pin_lock)) begin
                  next_st.pin_lock = i_bus.wdata[POS_PIN_LOCK];
               end
               // fail flag is clear-only from software
               if (!i_bus.wdata[POS_CLK_FAIL]) begin
                  next_st.clk_fail = 1'b0;
               end
            end
            ADDR_CLK_DIVIDER: begin
               next_st.recover = i_bus.wdata[POS_RECOVER];
               next_st.ratio_sel = i_bus.wdata[POS_RATIO_SEL +: 3];
               next_st.ratio_en = i_bus.wdata[POS_RATIO_EN];
               next_st.div_src = i_bus.wdata[POS_DIV_SOURCE +: 3];
               next_st.postscale = i_bus.wdata[POS_POSTSCALE +: 2];
               next_st.pll_force = i_bus.wdata[POS_PLL_FORCE];
            end
            ADDR_FRC_TUNE: begin
               next_st.tune_en = i_bus.wdata[POS_TUNE_EN];
               next_st.idle_stop = i_bus.wdata[POS_IDLE_STOP];
               next_st.ref_sel = i_bus.wdata[POS_REF_SEL];
               next_st.tol_pol = i_bus.wdata[POS_TOL_POL];
               next_st.range_pol = i_bus.wdata[POS_RANGE_POL];
               if (!st.tune_en) begin
                  next_st.frc_trim = i_bus.wdata[5:0];
               end
            end
            ADDR_DCO_TRIM: begin
               next_st.dco_trim = i_bus.wdata[5:0];
            end
            ADDR_DCO_CONTROL: begin
               next_st.dco_keep = i_bus.wdata[POS_DCO_KEEP];
               next_st.dco_fsel = i_bus.wdata[POS_DCO_FSEL +: 4];
            end
            ADDR_OUT_DIVISOR: begin
               next_st.divisor = i_bus.wdata[14:0];
            end
            default: begin
            end
         endcase
      end

      // a reserved divider source is refused, keeping the old one
      if (i_bus.wr && i_bus.addr == ADDR_CLK_DIVIDER &&
          i_bus.wdata[POS_DIV_SOURCE +: 3] == DIV_SRC_RSVD) begin
         next_st.div_src = st.div_src;
      end

      // interrupt recovery wins over a same-cycle write
      if (st.recover && i_irq) begin
         next_st.ratio_en = 1'b0;
      end

      // self-tune status and hardware trim
      next_st.in_tol = st.tune_en && i_tune_in_tol;
      next_st.out_range = st.tune_en && i_tune_out_range;
      if (tune_active && (i_tune_up ^ i_tune_down)) begin
         next_st.frc_trim = st.frc_trim + trim_step;
      end

      // pll settled follows lock only in a pll mode
      next_st.pll_settled = i_pll_lock &&
         (st.cur_osc == OSC_FRC_PLL || st.cur_osc == OSC_POSC_PLL);

      // switch sequencer
      case (st.sw)
         OCC_IDLE: begin
            if (st.switch_req) begin
               if (st.next_osc == st.cur_osc) begin
                  next_st.switch_req = 1'b0;
               end else begin
                  next_st.sw = OCC_WAIT;
                  next_st.pll_settled = 1'b0;
                  next_st.clk_fail = 1'b0;
               end
            end
         end
         OCC_WAIT: begin
            next_st.pll_settled = 1'b0;
            next_st.cnt = 4'h0;
            if (i_new_src_ready) begin
               next_st.sw = OCC_SETTLE;
            end
         end
         OCC_SETTLE: begin
            next_st.pll_settled = 1'b0;
            if (i_new_src_tick) begin
               next_st.cnt = st.cnt + 4'h1;
               if (st.cnt == SETTLE_CYCLES - 4'h1) begin
                  next_st.sw = OCC_IDLE;
                  next_st.cur_osc = st.next_osc;
                  next_st.switch_req = 1'b0;
               end
            end
         end
         default: begin
            next_st.sw = OCC_IDLE;
         end
      endcase

      // failure set wins over software clear
      if (i_fail_detect) begin
         next_st.clk_fail = 1'b1;
      end

      // read data, one cycle after the strobe
      next_st.rdata = 16'h0000;
      if (i_bus.rd) begin
         case (i_bus.addr)
            ADDR_OSC_CONTROL: begin
               next_st.rdata[POS_CUR_OSC +: 3] = st.cur_osc;
               next_st.rdata[POS_NEXT_OSC +: 3] = st.next_osc;
               next_st.rdata[POS_PIN_LOCK] = st.pin_lock;
               next_st.rdata[POS_PLL_SETTLED] = st.pll_settled;
               next_st.rdata[POS_CLK_FAIL] = st.clk_fail;
               next_st.rdata[POS_POSC_KEEP] = st.posc_keep;
               next_st.rdata[POS_SOSC_EN] = st.sosc_en;
               next_st.rdata[POS_SWITCH_REQ] = st.switch_req;
            end
            ADDR_CLK_DIVIDER: begin
               next_st.rdata[POS_RECOVER] = st.recover;
               next_st.rdata[POS_RATIO_SEL +: 3] = st.ratio_sel;
               next_st.rdata[POS_RATIO_EN] = st.ratio_en;
               next_st.rdata[POS_DIV_SOURCE +: 3] = st.div_src;
               next_st.rdata[POS_POSTSCALE +: 2] = st.postscale;
               next_st.rdata[POS_PLL_FORCE] = st.pll_force;
            end
            ADDR_FRC_TUNE: begin
               next_st.rdata[POS_TUNE_EN] = st.tune_en;
               next_st.rdata[POS_IDLE_STOP] = st.idle_stop;
               next_st.rdata[POS_REF_SEL] = st.ref_sel;
               next_st.rdata[POS_IN_TOL] = st.in_tol;
               next_st.rdata[POS_TOL_POL] = st.tol_pol;
               next_st.rdata[POS_OUT_RANGE] = st.out_range;
               next_st.rdata[POS_RANGE_POL] = st.range_pol;
               next_st.rdata[5:0] = st.frc_trim;
            end
            ADDR_DCO_TRIM: begin
               next_st.rdata[5:0] = st.dco_trim;
            end
            ADDR_DCO_CONTROL: begin
               next_st.rdata[POS_DCO_KEEP] = st.dco_keep;
               next_st.rdata[POS_DCO_FSEL +: 4] = st.dco_fsel;
            end
            ADDR_OUT_DIVISOR: begin
               next_st.rdata[14:0] = st.divisor;
            end
            ADDR_STATUS: begin
               next_st.rdata[1:0] = st.sw;
            end
            default: begin
               next_st.rdata = UNMAPPED_READ;
            end
         endcase
      end

      // control outputs, all registered
      next_st.ctl.posc_run = !i_sleep || st.posc_keep;
      next_st.ctl.dco_run = !i_sleep || st.dco_keep;
      next_st.ctl.sosc_run = st.sosc_en;
      next_st.ctl.pll_run = st.pll_force ||
         st.cur_osc == OSC_FRC_PLL || st.cur_osc == OSC_POSC_PLL;
      next_st.ctl.doze_active = st.ratio_en;
      next_st.ctl.doze_ratio = st.ratio_en ? st.ratio_sel : 3'h0;
      next_st.ctl.div_source = st.div_src;
      // usb-enabled restriction on postscale is software's duty
      next_st.ctl.postscale = st.postscale;
      next_st.ctl.frc_trim = st.frc_trim;
      next_st.ctl.dco_trim = st.dco_trim;
      next_st.ctl.dco_fsel = st.dco_fsel;
      next_st.ctl.divisor = st.divisor;
      next_st.ctl.cur_osc = st.cur_osc;
      next_st.ctl.tol_irq = st.tune_en && (st.in_tol ^ st.tol_pol);
      next_st.ctl.range_irq = st.tune_en &&
                              (st.out_range ^ st.range_pol);
   end

   // ****************************************************
   // registers
   // ****************************************************
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         st <= '0;
         st.ratio_sel <= RST_RATIO_SEL;
         st.ref_sel <= RST_REF_SEL;
         st.dco_fsel <= RST_DCO_FSEL;
         st.divisor <= RST_DIVISOR;
         st.ctl.doze_ratio <= 3'h0;
         st.ctl.dco_fsel <= RST_DCO_FSEL;
         st.ctl.divisor <= RST_DIVISOR;
      end else begin
         st <= next_st;
      end
   end

   assign o_rdata = st.rdata;
   assign o_ctl = st.ctl;

   // ****************************************************
   // checks
   // ****************************************************
   AST_FAIL_SET: assert property (@(posedge i_clock) disable iff (i_reset)
      i_fail_detect |=> st.clk_fail)
      else $error("fail flag not set");
   AST_POSC_SLEEP: assert property (@(posedge i_clock) disable iff (i_reset)
      (i_sleep && !st.posc_keep) |=> !o_ctl.posc_run)
      else $error("primary ran in sleep");
   AST_SWITCH_DONE: assert property (@(posedge i_clock) disable iff (i_reset)
      (st.sw == OCC_SETTLE && i_new_src_tick && st.cnt == 4'h9)
      |=> (!st.switch_req && st.cur_osc == $past(st.next_osc)))
      else $error("switch did not complete");
   AST_PLL_CLEAR: assert property (@(posedge i_clock) disable iff (i_reset)
      (st.sw != OCC_IDLE) |=> !st.pll_settled)
      else $error("pll flag during switch");
   AST_ONE_SHOT: assert property (@(posedge i_clock) disable iff (i_reset)
      (i_lock_one_shot && st.pin_lock) |=> st.pin_lock)
      else $error("one-shot lock cleared");
   AST_RECOVER: assert property (@(posedge i_clock) disable iff (i_reset)
      (st.recover && i_irq) |=> !st.ratio_en ##1 !o_ctl.doze_active)
      else $error("recover on irq failed");
   AST_TRIM_HOLD: assert property (@(posedge i_clock) disable iff (i_reset)
      (st.tune_en && !(i_tune_up ^ i_tune_down))
      |=> $stable(st.frc_trim))
      else $error("trim moved without tuner");
   AST_RANGE_HOLD: assert property (@(posedge i_clock) disable iff (i_reset)
      st.out_range |=> $stable(st.frc_trim) || !$past(st.tune_en))
      else $error("trim moved out of range");
   AST_PLL_RUN: assert property (@(posedge i_clock) disable iff (i_reset)
      st.pll_force |=> o_ctl.pll_run)
      else $error("forced pll not running");
   COV_SWITCH: cover property (@(posedge i_clock) disable iff (i_reset)
      st.sw == OCC_SETTLE ##1 st.sw == OCC_IDLE);
   COV_RECOVER: cover property (@(posedge i_clock) disable iff (i_reset)
      st.recover && i_irq && st.ratio_en);
   COV_TUNE: cover property (@(posedge i_clock) disable iff (i_reset)
      tune_active && i_tune_up);
endmodule

/* File: pkg/occ_pkg.sv */
package occ_pkg;

   // ****************************************************
   // register map
   // ****************************************************
   localparam logic [3:0] ADDR_OSC_CONTROL  = 4'h0;
   localparam logic [3:0] ADDR_CLK_DIVIDER  = 4'h1;
   localparam logic [3:0] ADDR_FRC_TUNE     = 4'h2;
   localparam logic [3:0] ADDR_DCO_TRIM     = 4'h3;
   localparam logic [3:0] ADDR_DCO_CONTROL  = 4'h4;
   localparam logic [3:0] ADDR_OUT_DIVISOR  = 4'h5;
   localparam logic [3:0] ADDR_STATUS       = 4'h6;

   // ****************************************************
   // field positions
   // ****************************************************
   localparam int POS_SWITCH_REQ    = 0;
   localparam int POS_SOSC_EN       = 1;
   localparam int POS_POSC_KEEP     = 2;
   localparam int POS_CLK_FAIL      = 3;
   localparam int POS_PLL_SETTLED   = 5;
   localparam int POS_PIN_LOCK      = 6;
   localparam int POS_NEXT_OSC      = 8;
   localparam int POS_CUR_OSC       = 12;
   localparam int POS_PLL_FORCE     = 5;
   localparam int POS_POSTSCALE     = 6;
   localparam int POS_DIV_SOURCE    = 8;
   localparam int POS_RATIO_EN      = 11;
   localparam int POS_RATIO_SEL     = 12;
   localparam int POS_RECOVER       = 15;
   localparam int POS_RANGE_POL     = 8;
   localparam int POS_OUT_RANGE     = 9;
   localparam int POS_TOL_POL       = 10;
   localparam int POS_IN_TOL        = 11;
   localparam int POS_REF_SEL       = 12;
   localparam int POS_IDLE_STOP     = 13;
   localparam int POS_TUNE_EN       = 15;
   localparam int POS_DCO_FSEL      = 8;
   localparam int POS_DCO_KEEP      = 13;

   // ****************************************************
   // reset values and codes
   // ****************************************************
   localparam logic [2:0]  RST_RATIO_SEL  = 3'h3;
   localparam logic        RST_REF_SEL    = 1'h1;
   localparam logic [3:0]  RST_DCO_FSEL   = 4'h7;
   localparam logic [14:0] RST_DIVISOR    = 15'h0001;
   localparam logic [2:0]  OSC_FRC_PLL    = 3'h1;
   localparam logic [2:0]  OSC_POSC_PLL   = 3'h3;
   localparam logic [2:0]  DIV_SRC_RSVD   = 3'h7;
   localparam logic [3:0]  SETTLE_CYCLES  = 4'ha;
   localparam logic [15:0] UNMAPPED_READ  = 16'h0000;

   // ****************************************************
   // types
   // ****************************************************
   typedef enum logic [1:0] {
      OCC_IDLE   = 2'b00,
      OCC_WAIT   = 2'b01,
      OCC_SETTLE = 2'b10
   } occ_sw_t;

   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } occ_bus_t;

   typedef struct packed {
      logic        posc_run;
      logic        dco_run;
      logic        sosc_run;
      logic        pll_run;
      logic        doze_active;
      logic [2:0]  doze_ratio;
      logic [2:0]  div_source;
      logic [1:0]  postscale;
      logic [5:0]  frc_trim;
      logic [5:0]  dco_trim;
      logic [3:0]  dco_fsel;
      logic [14:0] divisor;
      logic [2:0]  cur_osc;
      logic        tol_irq;
      logic        range_irq;
   } occ_ctl_t;

endpackage

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import occ_pkg::*;
   logic              i_clock = 1'b0;
   logic              i_reset = 1'b1;
   occ_bus_t          i_bus   = '0;
   logic [15:0]       o_rdata;
   logic              i_fail_detect = 1'b0, i_new_src_ready = 1'b0;
   logic              i_new_src_tick = 1'b0, i_pll_lock = 1'b0;
   logic              i_unlocked = 1'b0, i_lock_one_shot = 1'b0;
   logic              i_irq = 1'b0, i_sleep = 1'b0, i_idle = 1'b0;
   logic              i_tune_in_tol = 1'b0, i_tune_out_range = 1'b0;
   logic              i_tune_up = 1'b0, i_tune_down = 1'b0;
   occ_ctl_t          o_ctl;
   int                fail_count = 0;
   int                checked    = 0;

   occ_top i_occ_top (.i_clock(i_clock), .i_reset(i_reset), .i_bus(i_bus),
      .o_rdata(o_rdata), .i_fail_detect(i_fail_detect),
      .i_new_src_ready(i_new_src_ready), .i_new_src_tick(i_new_src_tick),
      .i_pll_lock(i_pll_lock), .i_unlocked(i_unlocked),
      .i_lock_one_shot(i_lock_one_shot), .i_initial_osc_config(3'h0),
      .i_irq(i_irq), .i_sleep(i_sleep), .i_idle(i_idle),
      .i_tune_in_tol(i_tune_in_tol), .i_tune_out_range(i_tune_out_range),
      .i_tune_up(i_tune_up), .i_tune_down(i_tune_down), .o_ctl(o_ctl));

   always #5 i_clock = ~i_clock;

   // ****************************************************
   // compare and bus tasks
   // ****************************************************
   task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_fld(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_clock);
      i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge i_clock);
      i_bus.wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd_chk(input logic [3:0] a, input logic [15:0] m,
                         input logic [15:0] e);
      @(posedge i_clock);
      i_bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge i_clock);
      i_bus.rd <= 1'b0;
      #1;
      chk_reg(o_rdata & m, e);
   endtask
   // outputs follow a write two cycles later
   task automatic settle();
      repeat (3) @(posedge i_clock);
      #1;
   endtask
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge i_clock);
         i_new_src_tick <= 1'b1;
         @(posedge i_clock);
         i_new_src_tick <= 1'b0;
      end
   endtask

   // ****************************************************
   // scenarios
   // ****************************************************
   task automatic t_reset_values();
      rd_chk(ADDR_CLK_DIVIDER, 16'hffff, 16'h3000);
      rd_chk(ADDR_FRC_TUNE, 16'hffff, 16'h1000);
      rd_chk(ADDR_DCO_CONTROL, 16'hffff, 16'h0700);
      rd_chk(ADDR_OUT_DIVISOR, 16'hffff, 16'h0001);
      rd_chk(ADDR_OSC_CONTROL, 16'hffff, 16'h0000);
      rd_chk(4'hf, 16'hffff, 16'h0000);
      $display("test reset_values done");
   endtask
   task automatic t_divider();
      wr(ADDR_CLK_DIVIDER, 16'hda60);
      rd_chk(ADDR_CLK_DIVIDER, 16'hffff, 16'hda60);
      settle();
      chk_fld(o_ctl.doze_active, 16'h1);
      chk_fld(o_ctl.doze_ratio, 16'h5);
      chk_fld(o_ctl.div_source, 16'h2);
      chk_fld(o_ctl.postscale, 16'h1);
      chk_fld(o_ctl.pll_run, 16'h1);
      wr(ADDR_CLK_DIVIDER, 16'hdf60);
      rd_chk(ADDR_CLK_DIVIDER, 16'hffff, 16'hda60);
      @(posedge i_clock);
      i_irq <= 1'b1;
      @(posedge i_clock);
      i_irq <= 1'b0;
      rd_chk(ADDR_CLK_DIVIDER, 16'hffff, 16'hd260);
      settle();
      chk_fld(o_ctl.doze_active, 16'h0);
      chk_fld(o_ctl.doze_ratio, 16'h0);
      wr(ADDR_CLK_DIVIDER, 16'h5800);
      @(posedge i_clock);
      i_irq <= 1'b1;
      @(posedge i_clock);
      i_irq <= 1'b0;
      rd_chk(ADDR_CLK_DIVIDER, 16'hffff, 16'h5800);
      settle();
      chk_fld(o_ctl.pll_run, 16'h0);
      $display("test divider done");
   endtask
   task automatic t_tune();
      wr(ADDR_FRC_TUNE, 16'h1020);
      rd_chk(ADDR_FRC_TUNE, 16'hffff, 16'h1020);
      // tune enable reads old state, so same-write trim would land
      wr(ADDR_FRC_TUNE, 16'ha020);
      rd_chk(ADDR_FRC_TUNE, 16'hffff, 16'ha020);
      i_tune_in_tol <= 1'b1;
      rd_chk(ADDR_FRC_TUNE, 16'hffff, 16'ha820);
      settle();
      chk_fld(o_ctl.tol_irq, 16'h1);
      chk_fld(o_ctl.range_irq, 16'h0);
      wr(ADDR_FRC_TUNE, 16'ha500);
      rd_chk(ADDR_FRC_TUNE, 16'hffff, 16'had20);
      settle();
      chk_fld(o_ctl.tol_irq, 16'h0);
      chk_fld(o_ctl.range_irq, 16'h1);
      i_tune_out_range <= 1'b1;
      @(posedge i_clock);
      i_tune_up <= 1'b1;
      @(posedge i_clock);
      i_tune_up <= 1'b0;
      rd_chk(ADDR_FRC_TUNE, 16'hffff, 16'haf20);
      i_tune_out_range <= 1'b0;
      i_idle <= 1'b1;
      @(posedge i_clock);
      i_tune_up <= 1'b1;
      @(posedge i_clock);
      i_tune_up <= 1'b0;
      rd_chk(ADDR_FRC_TUNE, 16'h003f, 16'h0020);
      i_idle <= 1'b0;
      @(posedge i_clock);
      i_tune_up <= 1'b1;
      @(posedge i_clock);
      i_tune_up <= 1'b0;
      settle();
      chk_fld(o_ctl.frc_trim, 16'h21);
      $display("test tune done");
   endtask
   task automatic t_switch();
      i_fail_detect <= 1'b1;
      @(posedge i_clock);
      i_fail_detect <= 1'b0;
      rd_chk(ADDR_OSC_CONTROL, 16'h0008, 16'h0008);
      wr(ADDR_OSC_CONTROL, 16'h0301);
      rd_chk(ADDR_OSC_CONTROL, 16'hffff, 16'h0301);
      i_new_src_ready <= 1'b1;
      i_pll_lock <= 1'b1;
      repeat (2) @(posedge i_clock);
      tick(8);
      rd_chk(ADDR_OSC_CONTROL, 16'h7001, 16'h0001);
      tick(2);
      settle();
      rd_chk(ADDR_OSC_CONTROL, 16'hffdf, 16'h3300);
      chk_fld(o_ctl.cur_osc, 16'h3);
      chk_fld(o_ctl.pll_run, 16'h1);
      wr(ADDR_OSC_CONTROL, 16'h0001);
      tick(12);
      settle();
      rd_chk(ADDR_OSC_CONTROL, 16'hffff, 16'h0000);
      chk_fld(o_ctl.pll_run, 16'h0);
      $display("test switch done");
   endtask
   task automatic t_lock_sleep();
      wr(ADDR_OSC_CONTROL, 16'h0040);
      rd_chk(ADDR_OSC_CONTROL, 16'h0040, 16'h0000);
      i_unlocked <= 1'b1;
      wr(ADDR_OSC_CONTROL, 16'h0040);
      rd_chk(ADDR_OSC_CONTROL, 16'h0040, 16'h0040);
      wr(ADDR_OSC_CONTROL, 16'h0000);
      rd_chk(ADDR_OSC_CONTROL, 16'h0040, 16'h0000);
      wr(ADDR_OSC_CONTROL, 16'h0040);
      i_lock_one_shot <= 1'b1;
      wr(ADDR_OSC_CONTROL, 16'h0000);
      rd_chk(ADDR_OSC_CONTROL, 16'h0040, 16'h0040);
      i_sleep <= 1'b1;
      settle();
      chk_fld(o_ctl.posc_run, 16'h0);
      chk_fld(o_ctl.dco_run, 16'h0);
      wr(ADDR_OSC_CONTROL, 16'h0006);
      settle();
      chk_fld(o_ctl.posc_run, 16'h1);
      chk_fld(o_ctl.sosc_run, 16'h1);
      @(posedge i_clock);
      i_sleep <= 1'b0;
      $display("test lock_sleep done");
   endtask
   task automatic t_dco_div();
      wr(ADDR_DCO_TRIM, 16'hffff);
      rd_chk(ADDR_DCO_TRIM, 16'hffff, 16'h003f);
      wr(ADDR_DCO_CONTROL, 16'hffff);
      rd_chk(ADDR_DCO_CONTROL, 16'hffff, 16'h2f00);
      wr(ADDR_DCO_CONTROL, 16'h0e00);
      settle();
      chk_fld(o_ctl.dco_fsel, 16'he);
      chk_fld(o_ctl.dco_trim, 16'h3f);
      wr(ADDR_OUT_DIVISOR, 16'hffff);
      rd_chk(ADDR_OUT_DIVISOR, 16'hffff, 16'h7fff);
      wr(ADDR_OUT_DIVISOR, 16'h0000);
      wr(4'hf, 16'hffff);
      settle();
      chk_fld(o_ctl.divisor, 16'h0000);
      $display("test dco_div done");
   endtask

   // ****************************************************
   // closing and sequence
   // ****************************************************
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // tests need about two hundred cycles
   initial begin
      #200000;
      fail_count++;
      report_and_stop();
   end

   initial begin
      repeat (20) @(posedge i_clock);
      i_reset <= 1'b0;
      repeat (2) @(posedge i_clock);
      t_reset_values();
      t_divider();
      t_tune();
      t_switch();
      t_lock_sleep();
      t_dco_div();
      report_and_stop();
   end
endmodule
